// >>> inc/char_move_map.svh
`ifndef CHAR_MOVE_MAP_SVH
`define CHAR_MOVE_MAP_SVH

// apb register byte offsets
`define GR_BASE_OFF     12'h000
`define CMD_OFF         12'h020
`define STAT_OFF        12'h024
`define LAST_OFF        12'h024

// command word fields
`define CMD_OP_HI       1
`define CMD_OP_LO       0
`define CMD_INLINE_BIT  2

// status word fields
`define STAT_C_BIT      0
`define STAT_V_BIT      1
`define STAT_Z_BIT      2
`define STAT_N_BIT      3
`define STAT_BUSY_BIT   4

// condition code vector positions
`define CC_C            0
`define CC_V            1
`define CC_Z            2
`define CC_N            3

// operand fetch steps of the in-line forms
`define STEP_SPTR       3'd0
`define STEP_SLEN       3'd1
`define STEP_SADR       3'd2
`define STEP_DPTR       3'd3
`define STEP_DLEN       3'd4
`define STEP_DADR       3'd5
`define STEP_FILL       3'd6
`define STEP_TBL        3'd7

// address arithmetic
`define WORD_STEP       16'h0002
`define BYTE_STEP       16'h0001
`define DESC_ADR_OFF    16'h0002
`define SIGN_BIT        15

// general register indices
`define R_SLEN          3'd0
`define R_SADR          3'd1
`define R_DLEN          3'd2
`define R_DADR          3'd3
`define R_FILL          3'd4
`define R_TBL           3'd5
`define R_PC            3'd7

`endif

// >>> inc/char_move_pkg.sv
package char_move_pkg;

   typedef enum logic [1:0] {op_fwd, op_rev, op_xlt, op_bad} op_t;

   typedef enum {s_idle, s_wlo, s_whi, s_setup, s_decide, s_src, s_tbl, s_wr, s_done} state_t;

   typedef struct packed {
      logic        valid;
      logic        write;
      logic [15:0] addr;
      logic [7:0]  wdata;
   } mem_req_t;

   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } apb_req_t;

endpackage : char_move_pkg

// >>> rtl/char_move.sv
// Notes on behaviour
// RULE_01 - n and z from length difference
// RULE_02 - v on signed overflow of subtraction
// RULE_03 - c acts as borrow of subtraction
// RULE_04 - reverse move pads most significant end
// RULE_05 - reverse move skips leading excess source
// RULE_06 - software loads descriptors and pad first
// RULE_07 - register form leaves remainder, clears r1-r3
// RULE_08 - in-line form fetches words, pc plus two
// RULE_09 - descriptor is length then address word
// RULE_10 - result as if source read first
// RULE_11 - reverse move direction by end addresses
// RULE_12 - empty source pads, empty destination writes nothing
// RULE_13 - equal lengths copy all, z set
// RULE_14 - r0 zero only when z or c
// RULE_15 - source byte indexes 256 byte table
// RULE_16 - translated move pads untranslated at end
// RULE_17 - translated move drops trailing excess source
// RULE_18 - table address returned unchanged in r5
// RULE_19 - in-line translated form fetches table word
// RULE_20 - translated move direction by start addresses
// RULE_21 - table overlap with destination not guarded
// RULE_22 - sixteen bit counters wrap around
`timescale 1ns/1ps
`include "char_move_map.svh"

module char_move
(
   input  wire logic                     clk,
   input  wire logic                     rst_n,
   input  wire char_move_pkg::apb_req_t  apb_in,
   output      logic [31:0]              prdata,
   output      logic                     pready,
   output      logic                     pslverr,
   output      char_move_pkg::mem_req_t  mem_out,
   input  wire logic                     mem_ready,
   input  wire logic [7:0]               mem_rdata,
   output      logic                     busy
);
   import char_move_pkg::*;

   state_t      state;
   state_t      next_state;
   mem_req_t    mem_q;
   mem_req_t    next_mem;
   logic [15:0] gr [0:7];
   logic [15:0] slen;
   logic [15:0] dlen;
   logic [15:0] sa;
   logic [15:0] da;
   logic [15:0] tbl;
   logic [15:0] ptr;
   logic [7:0]  fill;
   logic [7:0]  byte_q;
   logic [7:0]  lo_q;
   logic [2:0]  step;
   logic [3:0]  cc;
   op_t         op;
   logic        inline_q;
   logic        pad_first;
   logic        is_pad;

   // apb decode
   wire         setup_ph   = apb_in.psel && !apb_in.penable;
   wire         access_ph  = apb_in.psel && apb_in.penable;
   wire         aligned    = apb_in.paddr[1:0] == 2'b00;
   wire         hit_gr     = aligned && apb_in.paddr < `CMD_OFF;
   wire         hit_cmd    = aligned && apb_in.paddr == `CMD_OFF;
   wire         hit_stat   = aligned && apb_in.paddr == `STAT_OFF;
   wire         mapped     = aligned && apb_in.paddr <= `LAST_OFF;
   wire [2:0]   gr_idx     = apb_in.paddr[4:2];
   wire op_t    cmd_op     = op_t'(apb_in.pwdata[`CMD_OP_HI:`CMD_OP_LO]);
   wire         wr_block   = apb_in.pwrite && (busy || hit_stat || (hit_cmd && cmd_op == op_bad));
   wire         apb_wr     = access_ph && apb_in.pwrite && mapped && !wr_block;
   wire         gr_wr      = apb_wr && hit_gr;
   wire         cmd_go     = apb_wr && hit_cmd;
   wire [15:0]  stat_word  = {11'h000, busy, cc};
   wire [31:0]  rd_val     = hit_gr   ? {16'h0000, gr[gr_idx]} :
                             hit_stat ? {16'h0000, stat_word} : 32'h0000_0000;

   assign pready  = 1'b1;
   assign pslverr = access_ph && (!mapped || wr_block);
   assign busy    = state != s_idle;
   assign mem_out = mem_q;

   // length comparison
   wire [16:0]  diff_full  = {1'b0, slen} - {1'b0, dlen};
   wire [15:0]  diff       = diff_full[15:0];
   wire         borrow     = slen < dlen;
   wire         ovf        = (slen[`SIGN_BIT] != dlen[`SIGN_BIT]) && (dlen[`SIGN_BIT] == diff[`SIGN_BIT]); // [RULE_02]
   wire [15:0]  excess     = borrow ? 16'h0000 : diff;
   wire [15:0]  s_last     = slen + sa - `BYTE_STEP; // [RULE_22]
   wire [15:0]  d_last     = dlen + da - `BYTE_STEP;
   wire         rev_asc    = s_last >= d_last;       // [RULE_11]
   wire         fwd_asc    = sa >= da;               // [RULE_20]
   wire         asc        = (op == op_rev) ? pad_first : !pad_first; // [RULE_11] [RULE_20]
   wire         pad_cond   = pad_first ? (slen < dlen) : (slen == 16'h0000); // [RULE_12]

   // operand fetch address
   wire         from_pc    = step == `STEP_SPTR || step == `STEP_DPTR || step == `STEP_FILL || step == `STEP_TBL;
   wire         len_step   = step == `STEP_SLEN || step == `STEP_DLEN;
   wire [15:0]  fetch_base = from_pc ? gr[`R_PC] : len_step ? ptr : ptr + `DESC_ADR_OFF; // [RULE_09]
   wire [15:0]  word_in    = {mem_rdata, lo_q};
   wire         last_step  = step == `STEP_TBL || (step == `STEP_FILL && op != op_xlt); // [RULE_19]
   wire         mem_done   = mem_q.valid && mem_ready;
   wire [15:0]  step_adr   = asc ? `BYTE_STEP : 16'hffff;
   wire [15:0]  tbl_adr    = tbl + {8'h00, byte_q}; // [RULE_15]
   wire [15:0]  req_addr   = (state == s_wlo) ? fetch_base :
                             (state == s_whi) ? fetch_base + `BYTE_STEP :
                             (state == s_src) ? sa :
                             (state == s_tbl) ? tbl_adr : da;
   wire [7:0]   req_data   = is_pad ? fill : byte_q; // [RULE_16]

   // sequencer
   always_comb
   begin
      next_state = state;
      next_mem   = mem_q;
      case (state)
         s_idle:
         begin
            if (cmd_go)
               next_state = apb_in.pwdata[`CMD_INLINE_BIT] ? s_wlo : s_setup;
         end
         s_wlo, s_whi, s_src, s_tbl, s_wr:
         begin
            if (!mem_q.valid)
            begin
               next_mem.valid = 1'b1;
               next_mem.write = state == s_wr;
               next_mem.addr  = req_addr;
               next_mem.wdata = req_data;
            end
            else if (mem_ready)
            begin
               next_mem.valid = 1'b0;
               next_mem.write = 1'b0;
               case (state)
                  s_wlo: next_state = s_whi;
                  s_whi: next_state = last_step ? s_setup : s_wlo;
                  s_src: next_state = (op == op_xlt) ? s_tbl : s_wr;
                  s_tbl: next_state = s_wr;
                  default: next_state = s_decide;
               endcase
            end
         end
         s_setup: next_state = s_decide;
         s_decide:
         begin
            if (dlen == 16'h0000)
               next_state = s_done; // [RULE_12]
            else if (pad_cond)
               next_state = s_wr;
            else
               next_state = s_src;
         end
         default: next_state = s_idle;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state <= s_idle;
         mem_q <= '0;
      end
      else
      begin
         state <= next_state;
         mem_q <= next_mem;
      end
   end

   // apb read data captured in the setup phase
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         prdata <= 32'h0000_0000;
      else if (setup_ph)
         prdata <= rd_val;
   end

   // general registers
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         for (int i = 0; i < 8; i++)
            gr[i] <= 16'h0000;
      end
      else if (gr_wr)
         gr[gr_idx] <= apb_in.pwdata[15:0]; // [RULE_06]
      else if (state == s_whi && mem_done && from_pc)
         gr[`R_PC] <= gr[`R_PC] + `WORD_STEP; // [RULE_08]
      else if (state == s_done && !inline_q)
      begin
         gr[`R_SLEN] <= slen;               // [RULE_07] [RULE_14]
         gr[`R_SADR] <= 16'h0000;
         gr[`R_DLEN] <= 16'h0000;
         gr[`R_DADR] <= 16'h0000;
         gr[`R_FILL] <= {8'h00, fill};
         gr[`R_TBL]  <= tbl;                // [RULE_18]
      end
   end

   // command capture
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         op       <= op_fwd;
         inline_q <= 1'b0;
      end
      else if (cmd_go)
      begin
         op       <= cmd_op;
         inline_q <= apb_in.pwdata[`CMD_INLINE_BIT];
      end
   end

   // operand fetch
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         step <= `STEP_SPTR;
         lo_q <= 8'h00;
         ptr  <= 16'h0000;
      end
      else if (cmd_go)
         step <= `STEP_SPTR;
      else if (state == s_wlo && mem_done)
         lo_q <= mem_rdata;
      else if (state == s_whi && mem_done)
      begin
         step <= step + 3'd1;
         if (step == `STEP_SPTR || step == `STEP_DPTR)
            ptr <= word_in;
      end
   end

   // string descriptors and walk
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         slen      <= 16'h0000;
         dlen      <= 16'h0000;
         sa        <= 16'h0000;
         da        <= 16'h0000;
         fill      <= 8'h00;
         tbl       <= 16'h0000;
         pad_first <= 1'b0;
      end
      else if (cmd_go)
      begin
         slen <= gr[`R_SLEN];
         sa   <= gr[`R_SADR];
         dlen <= gr[`R_DLEN];
         da   <= gr[`R_DADR];
         fill <= gr[`R_FILL][7:0];
         tbl  <= gr[`R_TBL];
      end
      else if (state == s_whi && mem_done)
      begin
         case (step)
            `STEP_SLEN: slen <= word_in;
            `STEP_SADR: sa   <= word_in;
            `STEP_DLEN: dlen <= word_in;
            `STEP_DADR: da   <= word_in;
            `STEP_FILL: fill <= lo_q;
            `STEP_TBL:  tbl  <= word_in;
            default: ;
         endcase
      end
      else if (state == s_setup)
      begin
         // walk order keeps every source byte read before it can be overwritten
         if (op == op_rev)
         begin
            pad_first <= rev_asc;           // [RULE_04] [RULE_10]
            if (rev_asc)
               sa <= sa + excess;           // [RULE_05]
            else
            begin
               sa <= s_last;
               da <= d_last;
            end
         end
         else
         begin
            pad_first <= !fwd_asc;          // [RULE_17] [RULE_10]
            if (!fwd_asc)
            begin
               sa <= s_last - excess;
               da <= d_last;
            end
         end
      end
      else if (state == s_wr && mem_done)
      begin
         dlen <= dlen - `BYTE_STEP;         // [RULE_22]
         da   <= da + step_adr;
         if (!is_pad)
         begin
            slen <= slen - `BYTE_STEP;
            sa   <= sa + step_adr;
         end
      end
   end

   // byte path and condition codes
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         byte_q <= 8'h00;
         is_pad <= 1'b0;
         cc     <= 4'h0;
      end
      else
      begin
         if ((state == s_src || state == s_tbl) && mem_done)
            byte_q <= mem_rdata;            // [RULE_15]
         if (state == s_decide)
            is_pad <= pad_cond;
         if (state == s_setup)
         begin
            cc[`CC_N] <= diff[`SIGN_BIT];   // [RULE_01]
            cc[`CC_Z] <= diff == 16'h0000;  // [RULE_01] [RULE_13]
            cc[`CC_V] <= ovf;               // [RULE_02]
            cc[`CC_C] <= borrow;            // [RULE_03]
         end
      end
   end

   // the table is read through the same port as the destination; overlap is not checked [RULE_21]

   cc_sign_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_01]
      state == s_setup |=> cc[`CC_N] == $past(diff[`SIGN_BIT]) && cc[`CC_Z] == ($past(diff) == 16'h0000))
      else $error("n or z does not follow length difference");

   cc_ovf_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_02]
      state == s_setup |=> cc[`CC_V] == ($past(slen[15]) != $past(dlen[15]) && $past(dlen[15]) == $past(diff[15])))
      else $error("v does not follow overflow");

   cc_borrow_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_03]
      state == s_setup |=> cc[`CC_C] == ($past(slen) < $past(dlen)))
      else $error("c is not the borrow");

   pad_data_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_16]
      state == s_decide && dlen != 16'h0000 && pad_cond |=> ##1 mem_out.write && mem_out.wdata == fill)
      else $error("pad write does not carry fill");

   tbl_index_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_15]
      state == s_src && mem_done && op == op_xlt |=> ##1 mem_out.valid && mem_out.addr == tbl + {8'h00, byte_q})
      else $error("table read address wrong");

   r0_rule_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_14]
      state == s_done && !inline_q |=> (gr[0] == 16'h0000) == (cc[`CC_Z] || cc[`CC_C]))
      else $error("r0 zero does not match z or c");

   clr_regs_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_07]
      state == s_done && !inline_q |=> gr[1] == 16'h0000 && gr[2] == 16'h0000 && gr[3] == 16'h0000)
      else $error("r1 to r3 not cleared");

   pc_step_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_08]
      state == s_whi && mem_done && from_pc |=> gr[7] == $past(gr[7]) + 16'h0002)
      else $error("pc not advanced by two");

   inline_keep_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_08]
      state == s_done && inline_q |=> gr[0] == $past(gr[0]) && gr[5] == $past(gr[5]))
      else $error("in-line form changed registers");

   empty_dst_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_12]
      state == s_decide && dlen == 16'h0000 |=> state == s_done ##1 state == s_idle)
      else $error("empty destination not ended");

endmodule : char_move

// >>> bench/byte_mem.sv
`timescale 1ns/1ps
module byte_mem
   import char_move_pkg::*;
(
   input  wire logic                    clk,
   input  wire logic                    rst_n,
   input  wire char_move_pkg::mem_req_t req,
   input  wire logic                    slow,
   output      logic                    mem_ready,
   output      logic [7:0]              mem_rdata
);
   logic [7:0] m [0:65535];
   logic [1:0] cnt;

   // data only while answering, inverted otherwise
   assign mem_rdata = mem_ready ? m[req.addr] : ~m[req.addr];

   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cnt       <= 2'h0;
         mem_ready <= 1'b0;
      end
      else if (mem_ready || !req.valid)
      begin
         cnt       <= 2'h0;
         mem_ready <= 1'b0;
      end
      else
      begin
         cnt       <= cnt + 2'h1;
         mem_ready <= !slow || cnt == 2'h3;
      end
   end

   always @(posedge clk)
   begin
      if (req.valid && mem_ready && req.write)
         m[req.addr] <= req.wdata;
   end
endmodule : byte_mem

// >>> bench/tb.sv
`timescale 1ns/1ps
`include "char_move_map.svh"
module tb;
   import char_move_pkg::*;
   logic        clk;
   logic        rst_n;
   apb_req_t    apb_in;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   mem_req_t    mem_out;
   logic        mem_ready;
   logic [7:0]  mem_rdata;
   logic        busy;
   logic        slow;
   int          mismatches;
   int          n_tests;
   logic [7:0]  snap [0:65535];
   logic [31:0] q;
   logic        e;

   char_move i_dut (.clk(clk), .rst_n(rst_n), .apb_in(apb_in), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .mem_out(mem_out), .mem_ready(mem_ready), .mem_rdata(mem_rdata), .busy(busy));
   byte_mem i_mem (.clk(clk), .rst_n(rst_n), .req(mem_out), .slow(slow), .mem_ready(mem_ready),
      .mem_rdata(mem_rdata));

   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   task automatic final_report;
      $display("comparisons %0d, mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : final_report

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp)
      begin
         mismatches++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask : check

   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int   n;
      n = 0;
      apb_in <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
      @(posedge clk);
      apb_in.penable <= 1'b1;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (pready !== 1'b1 && n < 50);
      q = prdata;
      e = pslverr;
      check("pready", 32'h1, {31'h0, pready});
      apb_in <= '0;
      @(posedge clk);
   endtask : apb

   task automatic run(input logic [2:0] cmd);
      int n;
      n = 0;
      apb(1'b1, `CMD_OFF, {29'h0, cmd});
      check("cmd error", 32'h0, {31'h0, e});
      if (slow)
      begin
         apb(1'b0, `STAT_OFF, 32'h0);
         check("busy bit", 32'h1, {31'h0, q[`STAT_BUSY_BIT]});
         apb(1'b1, 12'h018, 32'h0000dead);
         check("busy write error", 32'h1, {31'h0, e});
      end
      do
      begin
         @(negedge clk);
         n++;
      end
      while (busy !== 1'b0 && n < 20000);
      check("done", 32'h0, {31'h0, busy});
      @(posedge clk);
   endtask : run

   task automatic scen(input logic [2:0] cmd, input logic [15:0] sl, dl, sa, da);
      logic [15:0] rv [0:7];
      logic [15:0] dw [0:7];
      logic [16:0] sub;
      logic [15:0] j;
      logic [15:0] k;
      logic [7:0]  x;
      logic        pad;
      int          i;
      slow <= ~slow;
      for (j = da - 16'h1; j != da + dl + 16'h1; j++)
         i_mem.m[j] = 8'hee;
      for (i = 0; i < 16; i++)
         i_mem.m[sa + 16'(i)] = 8'h41 + 8'(i);
      dw = '{16'h2008, 16'h200c, 16'h002a, 16'h3000, sl, sa, dl, da};
      for (i = 0; i < 8; i++)
         i_mem.m[16'h2000 + 16'(2 * i)] = dw[i][7:0];
      for (i = 0; i < 8; i++)
         i_mem.m[16'h2001 + 16'(2 * i)] = dw[i][15:8];
      if (cmd[2])
         rv = '{16'h1110, 16'h1111, 16'h1112, 16'h1113, 16'h1114, 16'h1115, 16'h1116, 16'h2000};
      else
         rv = '{sl, sa, dl, da, 16'h002a, 16'h3000, 16'h1116, 16'h2000};
      for (i = 0; i < 8; i++)
         apb(1'b1, 12'(4 * i), {16'h0, rv[i]});
      snap = i_mem.m;
      run(cmd);
      sub = {1'b0, sl} - {1'b0, dl};
      apb(1'b0, `STAT_OFF, 32'h0);
      check("status", {28'h0, sub[15], sub[15:0] == 16'h0, sl[15] != dl[15] && dl[15] == sub[15], sub[16]}, q);
      for (j = 0; j < dl; j++)
      begin
         k = cmd[1:0] == 2'd1 ? j + sl - dl : j;
         pad = cmd[1:0] == 2'd1 ? (dl > sl && j < dl - sl) : j >= sl;
         x = pad ? 8'h2a : snap[sa + k];
         if (cmd[1:0] == 2'd2 && !pad)
            x = snap[16'h3000 + {8'h0, x}];
         check("dst byte", {24'h0, x}, {24'h0, i_mem.m[da + j]});
      end
      check("guard low", {24'h0, snap[da - 16'h1]}, {24'h0, i_mem.m[da - 16'h1]});
      check("guard high", {24'h0, snap[da + dl]}, {24'h0, i_mem.m[da + dl]});
      if (cmd[2])
         rv[7] = cmd[1:0] == 2'd2 ? 16'h2008 : 16'h2006;
      else
      begin
         rv[0] = sl > dl ? sl - dl : 16'h0;
         for (i = 1; i < 4; i++)
            rv[i] = 16'h0;
      end
      for (i = 0; i < 8; i++)
      begin
         apb(1'b0, 12'(4 * i), 32'h0);
         check("register", {16'h0, rv[i]}, q);
      end
      $display("test with command %h done", cmd);
   endtask : scen

   initial
   begin
      #3000000;
      mismatches++;
      final_report();
   end

   initial
   begin
      apb_in = '0;
      slow = 1'b0;
      rst_n = 1'b0;
      mismatches = 0;
      n_tests = 0;
      for (int a = 0; a < 65536; a++)
         i_mem.m[a] = 8'(a) ^ 8'(a >> 8);
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      apb(1'b0, `STAT_OFF, 32'h0);
      check("reset status", 32'h0, q);
      apb(1'b0, 12'h028, 32'h0);
      check("unmapped", 32'h1, {31'h0, e});
      apb(1'b1, 12'h002, 32'h1);
      check("misaligned", 32'h1, {31'h0, e});
      apb(1'b1, `STAT_OFF, 32'h1);
      check("status write", 32'h1, {31'h0, e});
      apb(1'b1, `CMD_OFF, 32'h3);
      check("bad op", 32'h1, {31'h0, e});
      apb(1'b0, `STAT_OFF, 32'h0);
      check("bad op idle", 32'h0, q);
      $display("test of bus refusals done");
      scen(3'b000, 16'd5, 16'd8, 16'h0100, 16'h0200);
      scen(3'b100, 16'd8, 16'd5, 16'h0300, 16'h0100);
      scen(3'b001, 16'd3, 16'd6, 16'h0100, 16'h0200);
      scen(3'b101, 16'd7, 16'd4, 16'h0400, 16'h0100);
      scen(3'b001, 16'd6, 16'd6, 16'h0500, 16'h0502);
      scen(3'b010, 16'd4, 16'd7, 16'h0600, 16'h0700);
      scen(3'b110, 16'd6, 16'd3, 16'h0800, 16'h0600);
      scen(3'b010, 16'd5, 16'd5, 16'h0900, 16'h0903);
      scen(3'b000, 16'd0, 16'd4, 16'h0a00, 16'h0b00);
      scen(3'b101, 16'd4, 16'd0, 16'h0c00, 16'h0d00);
      scen(3'b010, 16'h8000, 16'd1, 16'h0f00, 16'h0f80);
      scen(3'b000, 16'd6, 16'd6, 16'h0e00, 16'h0e02);
      scen(3'b100, 16'd4, 16'd4, 16'h0010, 16'hfffe);
      scen(3'b000, 16'd2, 16'd8, 16'h0101, 16'h0100);
      scen(3'b110, 16'd2, 16'd6, 16'h0a81, 16'h0a80);
      final_report();
   end
endmodule : tb
